/* include/cbpw_params.svh */
// constants of the bridge power and wake block
// assumes it is included by its bare name from include/
`ifndef CBPW_PARAMS_SVH
`define CBPW_PARAMS_SVH

// address spaces on the configuration port
`define CBPW_SPACE_CFG 2'h0
`define CBPW_SPACE_EXCA 2'h1
`define CBPW_SPACE_CB 2'h2

// configuration space byte addresses
`define CBPW_OFF_COMMAND 8'h04
`define CBPW_OFF_STATUS 8'h06
`define CBPW_OFF_CAP_PTR 8'h14
`define CBPW_OFF_SYS_CTRL 8'h80
`define CBPW_OFF_EVENT 8'h88
`define CBPW_OFF_EVENT_EN 8'h89
`define CBPW_OFF_MF_ROUTE 8'h8c
`define CBPW_OFF_CARD_CTRL 8'h91
`define CBPW_OFF_PM_HDR 8'ha0
`define CBPW_OFF_PM_CAPS 8'ha2
`define CBPW_OFF_PM_CSR 8'ha4
// exca and cardbus socket spaces
`define CBPW_OFF_EXCA_INTGEN 8'h03
`define CBPW_OFF_CB_MASK 8'h04

// field positions
`define CBPW_BIT_IO_EN 0
`define CBPW_BIT_MEM_EN 1
`define CBPW_BIT_CAPABILITY_LIST_FLAG 4
`define CBPW_BIT_PIN_SEL 0
`define CBPW_BIT_ROUTE_MF2 0
`define CBPW_BIT_ROUTE_MF4 1
`define CBPW_BIT_RING_OE 7
`define CBPW_BIT_RING_MASK 7
`define CBPW_BIT_CSC_MASK 0
`define CBPW_BIT_PME_EN 8
`define CBPW_BIT_PME_STS 15
`define CBPW_BIT_EV_RING 0
`define CBPW_BIT_EV_CSC 1
`define CBPW_BIT_EV_WAKE 2

// fixed read values
`define CBPW_CAP_PTR_VAL 8'ha0
`define CBPW_PM_CAP_ID 8'h01
`define CBPW_PM_NEXT 8'h00
`define CBPW_PM_CAPS_VAL 16'h0002
`define CBPW_EVENT_BITS 8'h07

`endif

/* include/cbpw_pkg.sv */
// types of the bridge power and wake block
// assumes nothing beyond a SystemVerilog compiler
package cbpw_pkg;

    typedef enum logic [5:0] {
        CBPW_D0_UNINIT = 6'h01,
        CBPW_D0_ACTIVE = 6'h02,
        CBPW_D1 = 6'h04,
        CBPW_D2 = 6'h08,
        CBPW_D3_HOT = 6'h10,
        CBPW_D3_COLD = 6'h20
    } cbpw_pstate_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] space;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cbpw_cfg_req_t;

    typedef struct packed {
        logic card_ring_input;
        logic card16_powered;
        logic cardbus_powered;
        logic cardbus_wake_request;
        logic cardbus_status_change;
    } cbpw_card_t;

endpackage

/* design/cbpw_wake_route.sv */
// ring/wake event masking and pin routing, all outputs registered
// assumes card inputs are synchronous to clk; stays live during sleep-hold
`include "cbpw_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cbpw_wake_route
    import cbpw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire cbpw_card_t card,
    input wire logic ring_mask_enable,
    input wire logic status_change_mask,
    input wire logic ring_output_enable,
    input wire logic ring_pin_select,
    input wire logic route_mf2,
    input wire logic route_mf4,
    input wire logic pme_active,
    output logic ring_event,
    output logic csc_event,
    output logic wake_event,
    output logic ring_pme_pin_n,
    output logic multifunction_pin_two_n,
    output logic multifunction_pin_four_n
);

    logic ring_src;
    logic wake_src;
    logic csc_src;
    logic ring_wake;

    // ring only counts with a powered 16-bit card
    assign ring_src = card.card_ring_input & card.card16_powered & ring_mask_enable;
    // wake from a powered-down card, shares the status-change mask
    assign wake_src = card.cardbus_wake_request & ~card.cardbus_powered
        & status_change_mask;
    assign csc_src = card.cardbus_status_change & card.cardbus_powered & status_change_mask;
    assign ring_wake = (ring_src | wake_src | csc_src) & ring_output_enable;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ring_event <= 1'b0;
            csc_event <= 1'b0;
            wake_event <= 1'b0;
        end else begin
            ring_event <= ring_src;
            csc_event <= csc_src;
            wake_event <= wake_src;
        end
    end

    // shared pin: ring/wake wins while ring output enable is set; with it clear pme drives the pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ring_pme_pin_n <= 1'b1;
            multifunction_pin_two_n <= 1'b1;
            multifunction_pin_four_n <= 1'b1;
        end else if (!ring_pin_select) begin
            ring_pme_pin_n <= ~(ring_output_enable ? ring_wake : pme_active);
            multifunction_pin_two_n <= 1'b1;
            multifunction_pin_four_n <= 1'b1;
        end else begin
            ring_pme_pin_n <= ~pme_active;
            multifunction_pin_two_n <= ~(ring_wake & route_mf2);
            multifunction_pin_four_n <= ~(ring_wake & route_mf4);
        end
    end

endmodule

`default_nettype wire

/* design/cbpw_top.sv */
// power state, wake context, suspend and event registers of the bridge
// assumes a config port synchronous to the host bus clock, one request at a time
// Overview of operation
// - sleep-hold blocks both resets, so no register is cleared by them
// - sleep-hold floats bus outputs and gates clock unless grant is active
// - ring/wake and multifunction outputs keep working during sleep-hold
// - ring, wake request or status change may drive the ring/wake output
// - card ring passes only with ring mask set and 16-bit card powered
// - cardbus wake uses the same status-change mask bit 0
// - ring/wake needs ring output enable; routes to shared or multifunction pins
// - pme signalling needs the wake-event enable bit 8
// - pin select 0 shares the pin; ring/wake wins with ring output enable set, else pme drives it
// - no pme and no events while in uninitialized full power
// - io and memory enable both set moves uninitialized to active
// - host reset release leaves D3cold to uninit; global reset forces uninit
// - two-bit power field shows only D0, D1, D2 and D3hot
// - capability list flag in status reads one
// - capability pointer sits at 14h and points at the first block
// - power block starts with id 01h and next pointer zero
// - block at A0h: id, next, caps, control/status, extensions, data
// - global reset returns every register to its default
// - host reset keeps wake context when pme enabled, else clears it too; routing, event enable and event status stay
// - system event when a status bit and its enable are both set
// - wake-event enable set stops host reset clearing wake-context bits
// - sleep-hold gates host reset, global reset and the bus clock
`include "cbpw_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cbpw_top
    import cbpw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic global_reset_in,
    input wire logic host_bus_reset_in,
    input wire logic sleep_hold,
    input wire logic bus_grant,
    input wire cbpw_cfg_req_t cfg_req,
    input wire cbpw_card_t card,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    output logic host_bus_float,
    output logic bus_clock_gated,
    output logic system_event,
    output logic [1:0] power_state_field,
    output logic d0_active,
    output logic ring_pme_pin_n,
    output logic multifunction_pin_two_n,
    output logic multifunction_pin_four_n
);

    function automatic logic hit(input cbpw_cfg_req_t r, input logic [1:0] sp,
                                 input logic [7:0] off);
        hit = (r.space == sp) && (r.addr[7:2] == off[7:2]);
    endfunction

    function automatic logic [7:0] lane(input cbpw_cfg_req_t r, input logic [7:0] off);
        lane = r.wdata[off[1:0]*8 +: 8];
    endfunction

    function automatic logic lane_on(input cbpw_cfg_req_t r, input logic [7:0] off);
        lane_on = r.be[off[1:0]];
    endfunction

    cbpw_pstate_t pstate;
    cbpw_pstate_t next_pstate;
    logic io_en;
    logic mem_en;
    logic ring_pin_select;
    logic route_mf2;
    logic route_mf4;
    logic ring_output_enable;
    logic ring_mask_enable;
    logic status_change_mask;
    logic pme_enable;
    logic pme_status;
    logic [7:0] event_status;
    logic [7:0] event_enable;
    logic bus_gate;
    logic global_clear;
    logic host_clear;
    logic ordinary_clear;
    logic context_clear;
    logic wr_ok;
    logic rd_ok;
    logic ring_event;
    logic csc_event;
    logic wake_event;
    logic pme_active;
    logic [7:0] event_set;
    logic [7:0] event_w1c;
    logic pm_wr;
    logic [1:0] next_field;
    logic [31:0] next_rdata;

    // both resets pass only while sleep-hold is low
    assign global_clear = global_reset_in & ~sleep_hold;
    assign host_clear = host_bus_reset_in & ~sleep_hold;
    assign ordinary_clear = global_clear | host_clear;
    // wake context survives host reset only with pme enabled
    assign context_clear = global_clear | (host_clear & ~pme_enable);

    // a transaction under grant finishes before the clock is gated
    assign bus_gate = sleep_hold & ~bus_grant;
    assign wr_ok = cfg_req.wr & ~bus_gate & ~ordinary_clear;
    assign rd_ok = cfg_req.rd & ~bus_gate;

    assign pm_wr = wr_ok && hit(cfg_req, `CBPW_SPACE_CFG, `CBPW_OFF_PM_CSR);

    assign event_set = {5'h00, wake_event, csc_event, ring_event};
    assign event_w1c = (wr_ok && hit(cfg_req, `CBPW_SPACE_CFG, `CBPW_OFF_EVENT)
        && lane_on(cfg_req, `CBPW_OFF_EVENT)) ? lane(cfg_req, `CBPW_OFF_EVENT) : 8'h00;

    // uninitialized full power may not signal pme
    assign pme_active = pme_enable & pme_status & (pstate != CBPW_D0_UNINIT);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_bus_float <= 1'b0;
            bus_clock_gated <= 1'b0;
        end else begin
            host_bus_float <= bus_gate;
            bus_clock_gated <= bus_gate;
        end
    end

    // command enables clear on either reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            io_en <= 1'b0;
            mem_en <= 1'b0;
        end else if (ordinary_clear) begin
            io_en <= 1'b0;
            mem_en <= 1'b0;
        end else if (wr_ok && hit(cfg_req, `CBPW_SPACE_CFG, `CBPW_OFF_COMMAND)
                     && lane_on(cfg_req, `CBPW_OFF_COMMAND)) begin
            io_en <= cfg_req.wdata[`CBPW_BIT_IO_EN];
            mem_en <= cfg_req.wdata[`CBPW_BIT_MEM_EN];
        end
    end

    // routing and enables clear only on global reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ring_pin_select <= 1'b0;
            route_mf2 <= 1'b0;
            route_mf4 <= 1'b0;
            ring_output_enable <= 1'b0;
            event_enable <= 8'h00;
        end else if (global_clear) begin
            ring_pin_select <= 1'b0;
            route_mf2 <= 1'b0;
            route_mf4 <= 1'b0;
            ring_output_enable <= 1'b0;
            event_enable <= 8'h00;
        end else if (wr_ok) begin
            if (hit(cfg_req, `CBPW_SPACE_CFG, `CBPW_OFF_SYS_CTRL)
                && lane_on(cfg_req, `CBPW_OFF_SYS_CTRL)) begin
                ring_pin_select <= cfg_req.wdata[`CBPW_BIT_PIN_SEL];
            end
            if (hit(cfg_req, `CBPW_SPACE_CFG, `CBPW_OFF_MF_ROUTE)
                && lane_on(cfg_req, `CBPW_OFF_MF_ROUTE)) begin
                route_mf2 <= cfg_req.wdata[`CBPW_BIT_ROUTE_MF2];
                route_mf4 <= cfg_req.wdata[`CBPW_BIT_ROUTE_MF4];
            end
            if (hit(cfg_req, `CBPW_SPACE_CFG, `CBPW_OFF_CARD_CTRL)
                && lane_on(cfg_req, `CBPW_OFF_CARD_CTRL)) begin
                ring_output_enable <= cfg_req.wdata[8 + `CBPW_BIT_RING_OE];
            end
            if (hit(cfg_req, `CBPW_SPACE_CFG, `CBPW_OFF_EVENT_EN)
                && lane_on(cfg_req, `CBPW_OFF_EVENT_EN)) begin
                event_enable <= lane(cfg_req, `CBPW_OFF_EVENT_EN) & `CBPW_EVENT_BITS;
            end
        end
    end

    // event status: hardware set beats a write-one clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            event_status <= 8'h00;
        end else if (global_clear) begin
            event_status <= 8'h00;
        end else begin
            event_status <= ((event_status & ~event_w1c) | event_set) & `CBPW_EVENT_BITS;
        end
    end

    // socket masks: ring mask is ordinary, status-change mask is wake context
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ring_mask_enable <= 1'b0;
        end else if (ordinary_clear) begin
            ring_mask_enable <= 1'b0;
        end else if (wr_ok && hit(cfg_req, `CBPW_SPACE_EXCA, `CBPW_OFF_EXCA_INTGEN)
                     && lane_on(cfg_req, `CBPW_OFF_EXCA_INTGEN)) begin
            ring_mask_enable <= cfg_req.wdata[24 + `CBPW_BIT_RING_MASK];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_change_mask <= 1'b0;
        end else if (context_clear) begin
            status_change_mask <= 1'b0;
        end else if (wr_ok && hit(cfg_req, `CBPW_SPACE_CB, `CBPW_OFF_CB_MASK)
                     && lane_on(cfg_req, `CBPW_OFF_CB_MASK)) begin
            status_change_mask <= cfg_req.wdata[`CBPW_BIT_CSC_MASK];
        end
    end

    // pme enable and status are wake context
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pme_enable <= 1'b0;
            pme_status <= 1'b0;
        end else if (context_clear) begin
            pme_enable <= 1'b0;
            pme_status <= 1'b0;
        end else begin
            if (pm_wr && cfg_req.be[1]) begin
                pme_enable <= cfg_req.wdata[`CBPW_BIT_PME_EN];
            end
            // a new wake in the clearing cycle is kept
            pme_status <= (pme_status & ~(pm_wr && cfg_req.be[1]
                && cfg_req.wdata[`CBPW_BIT_PME_STS])) | ring_event | wake_event | csc_event;
        end
    end

    always_comb begin
        next_field = cfg_req.wdata[1:0];
        next_pstate = pstate;
        if (global_clear) begin
            next_pstate = CBPW_D0_UNINIT;
        end else if (host_clear) begin
            // host reset from D3hot is the power-removed state
            if (pstate == CBPW_D3_HOT || pstate == CBPW_D3_COLD) begin
                next_pstate = CBPW_D3_COLD;
            end else begin
                next_pstate = CBPW_D0_UNINIT;
            end
        end else begin
            unique case (pstate)
                CBPW_D3_COLD: begin
                    next_pstate = CBPW_D0_UNINIT;
                end
                CBPW_D0_UNINIT: begin
                    if (io_en && mem_en) begin
                        next_pstate = CBPW_D0_ACTIVE;
                    end else if (pm_wr && cfg_req.be[0] && next_field != 2'h0) begin
                        next_pstate = (next_field == 2'h1) ? CBPW_D1 :
                            (next_field == 2'h2) ? CBPW_D2 : CBPW_D3_HOT;
                    end
                end
                CBPW_D0_ACTIVE, CBPW_D1, CBPW_D2, CBPW_D3_HOT: begin
                    if (pm_wr && cfg_req.be[0]) begin
                        next_pstate = (next_field == 2'h0) ? CBPW_D0_ACTIVE :
                            (next_field == 2'h1) ? CBPW_D1 :
                            (next_field == 2'h2) ? CBPW_D2 : CBPW_D3_HOT;
                    end
                end
                default: begin
                    next_pstate = CBPW_D0_UNINIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pstate <= CBPW_D0_UNINIT;
        end else begin
            pstate <= next_pstate;
        end
    end

    // D3cold is not software visible; it reads as D3hot
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_state_field <= 2'h0;
            d0_active <= 1'b0;
        end else begin
            unique case (next_pstate)
                CBPW_D1: power_state_field <= 2'h1;
                CBPW_D2: power_state_field <= 2'h2;
                CBPW_D3_HOT, CBPW_D3_COLD: power_state_field <= 2'h3;
                default: power_state_field <= 2'h0;
            endcase
            d0_active <= (next_pstate == CBPW_D0_ACTIVE);
        end
    end

    // events stay quiet until the function is configured
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            system_event <= 1'b0;
        end else begin
            system_event <= (|(event_status & event_enable))
                && (pstate != CBPW_D0_UNINIT);
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (cfg_req.space)
            `CBPW_SPACE_CFG: begin
                unique case ({2'h0, cfg_req.addr[7:2]})
                    `CBPW_OFF_COMMAND >> 2: begin
                        next_rdata[`CBPW_BIT_IO_EN] = io_en;
                        next_rdata[`CBPW_BIT_MEM_EN] = mem_en;
                        next_rdata[16 + `CBPW_BIT_CAPABILITY_LIST_FLAG] = 1'b1;
                    end
                    `CBPW_OFF_CAP_PTR >> 2: next_rdata[7:0] = `CBPW_CAP_PTR_VAL;
                    `CBPW_OFF_SYS_CTRL >> 2: next_rdata[`CBPW_BIT_PIN_SEL] = ring_pin_select;
                    `CBPW_OFF_EVENT >> 2: next_rdata[15:0] = {event_enable, event_status};
                    `CBPW_OFF_MF_ROUTE >> 2: next_rdata[1:0] = {route_mf4, route_mf2};
                    `CBPW_OFF_CARD_CTRL >> 2: next_rdata[8 + `CBPW_BIT_RING_OE] =
                        ring_output_enable;
                    `CBPW_OFF_PM_HDR >> 2: next_rdata = {`CBPW_PM_CAPS_VAL, `CBPW_PM_NEXT,
                        `CBPW_PM_CAP_ID};
                    `CBPW_OFF_PM_CSR >> 2: begin
                        next_rdata[1:0] = power_state_field;
                        next_rdata[`CBPW_BIT_PME_EN] = pme_enable;
                        next_rdata[`CBPW_BIT_PME_STS] = pme_status;
                    end
                    default: next_rdata = 32'h0000_0000;
                endcase
            end
            `CBPW_SPACE_EXCA: begin
                if (hit(cfg_req, `CBPW_SPACE_EXCA, `CBPW_OFF_EXCA_INTGEN)) begin
                    next_rdata[24 + `CBPW_BIT_RING_MASK] = ring_mask_enable;
                end
            end
            `CBPW_SPACE_CB: begin
                if (hit(cfg_req, `CBPW_SPACE_CB, `CBPW_OFF_CB_MASK)) begin
                    next_rdata[`CBPW_BIT_CSC_MASK] = status_change_mask;
                end
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_ack <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack <= rd_ok | (cfg_req.wr & ~bus_gate);
            cfg_rdata <= rd_ok ? next_rdata : 32'h0000_0000;
        end
    end

    // ring/wake path runs on during sleep-hold; only its own enables stop it
    cbpw_wake_route u_route (
        .clk(clk),
        .reset(reset),
        .card(card),
        .ring_mask_enable(ring_mask_enable),
        .status_change_mask(status_change_mask),
        .ring_output_enable(ring_output_enable),
        .ring_pin_select(ring_pin_select),
        .route_mf2(route_mf2),
        .route_mf4(route_mf4),
        .pme_active(pme_active),
        .ring_event(ring_event),
        .csc_event(csc_event),
        .wake_event(wake_event),
        .ring_pme_pin_n(ring_pme_pin_n),
        .multifunction_pin_two_n(multifunction_pin_two_n),
        .multifunction_pin_four_n(multifunction_pin_four_n)
    );

endmodule

`default_nettype wire

/* testbench/cbpw_host_model.sv */
// host bus arbiter model facing the bridge
// assumes the bench raises want_bus only around its own requests
`timescale 1ns/1ps
`default_nettype none
module cbpw_host_model (
    input wire logic want_bus,
    output logic bus_grant
);
    // grant only for a real transfer, never parked on the bridge
    assign bus_grant = want_bus;
endmodule
`default_nettype wire

/* testbench/cbpw_top_chk.sv */
// port assertions of the bridge power and wake block
// assumes binding into cbpw_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cbpw_top_chk
    import cbpw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic global_reset_in,
    input wire logic host_bus_reset_in,
    input wire logic sleep_hold,
    input wire logic bus_grant,
    input wire cbpw_cfg_req_t cfg_req,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic host_bus_float,
    input wire logic bus_clock_gated,
    input wire logic system_event,
    input wire logic [1:0] power_state_field,
    input wire logic d0_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic off_bus;
    logic uninit;
    assign off_bus = sleep_hold & ~bus_grant;
    assign uninit = (power_state_field == 2'h0) & ~d0_active;
    sequence s_take;
        (cfg_req.rd | cfg_req.wr) & ~off_bus;
    endsequence
    sequence s_uninit2;
        uninit [*2];
    endsequence
    property p_float;
        !$past(reset) |-> host_bus_float == $past(off_bus);
    endproperty
    a_float: assert property (p_float) else $error("float wrong");
    property p_gated;
        bus_clock_gated == host_bus_float;
    endproperty
    a_gated: assert property (p_gated) else $error("clock gate wrong");
    property p_refuse;
        (cfg_req.rd | cfg_req.wr) & off_bus |=> !cfg_ack;
    endproperty
    a_refuse: assert property (p_refuse) else $error("ack while floating");
    property p_ack;
        s_take |=> cfg_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_pmhdr;
        s_take ##0 (cfg_req.rd && cfg_req.space == 2'h0 && cfg_req.addr == 8'ha0)
            |=> cfg_rdata == 32'h0002_0001;
    endproperty
    a_pmhdr: assert property (p_pmhdr) else $error("pm header wrong");
    property p_quiet;
        s_uninit2 |-> !system_event;
    endproperty
    a_quiet: assert property (p_quiet) else $error("event when uninit");
    property p_global_reset_in;
        global_reset_in & ~sleep_hold |-> ##[1:2] uninit;
    endproperty
    a_global_reset_in: assert property (p_global_reset_in) else $error("not uninit");
    property p_hold;
        sleep_hold & (global_reset_in | host_bus_reset_in) & !cfg_req.wr & !$past(cfg_req.wr)
            |=> $stable(power_state_field) && $stable(d0_active);
    endproperty
    a_hold: assert property (p_hold) else $error("state lost in hold");
endmodule
bind cbpw_top cbpw_top_chk chk (.*);
`default_nettype wire

/* testbench/test_cbpw_top.sv */
// bench of the bridge power and wake block
// assumes the arbiter model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module test_cbpw_top;
    import cbpw_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] mask;
        logic [31:0] exp;
    } cbpw_row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic global_reset_in = 1'b0;
    logic host_bus_reset_in = 1'b0;
    logic sleep_hold = 1'b0;
    logic want_bus = 1'b0;
    logic bus_grant;
    cbpw_cfg_req_t cfg_req = '0;
    cbpw_card_t card = '0;
    logic cfg_ack, host_bus_float, bus_clock_gated, system_event, d0_active;
    logic ring_pme_pin_n, multifunction_pin_two_n, multifunction_pin_four_n;
    logic [1:0] power_state_field;
    logic [31:0] cfg_rdata, rdata;
    int fail_count = 0;
    int checked = 0;
    cbpw_row_t rows [5] = '{'{8'h04, 32'h0010_0003, 32'h0010_0000},
        '{8'h14, 32'hff, 32'ha0}, '{8'ha0, '1, 32'h0002_0001},
        '{8'ha4, 32'h8103, 32'h0}, '{8'he0, '1, 32'h0}};
    cbpw_top dut (.*);
    cbpw_host_model host (.*);
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cfg(input logic w, input logic [1:0] sp, input logic [7:0] a,
            input logic [3:0] be, input logic [31:0] wd);
        int n;
        @(negedge clk);
        cfg_req = '{~w, w, sp, a, be, wd};
        want_bus = 1'b1;
        @(negedge clk);
        cfg_req = '0;
        want_bus = 1'b0;
        // bounded: a lost ack must not hang the run
        for (n = 0; n < 4 && cfg_ack !== 1'b1; n++) @(negedge clk);
        if (n == 4) begin
            fail_count++;
            close_out();
        end
        rdata = cfg_rdata;
    endtask
    task automatic wr(input logic [1:0] sp, input logic [7:0] a, input logic [3:0] be,
            input logic [31:0] wd);
        cfg(1'b1, sp, a, be, wd);
    endtask
    task automatic rd(input logic [7:0] a);
        cfg(1'b0, 2'h0, a, 4'hf, 32'h0);
    endtask
    initial forever #12.5 clk = ~clk;
    initial begin
        tick(10);
        reset = 1'b0;
        foreach (rows[i]) begin
            rd(rows[i].addr);
            check(rdata & rows[i].mask, rows[i].exp);
        end
        wr(2'h1, 8'h00, 4'h8, 32'h8000_0000);
        wr(2'h0, 8'h90, 4'h2, 32'h8000);
        wr(2'h0, 8'h88, 4'h2, 32'h0700);
        wr(2'h2, 8'h04, 4'h1, 32'h1);
        wr(2'h0, 8'ha4, 4'h2, 32'h0100);
        card = 5'b10000;
        tick(2);
        check(ring_pme_pin_n, 1'b1);
        card = 5'b11000;
        tick(2);
        check(ring_pme_pin_n, 1'b0);
        check(system_event, 1'b0);
        wr(2'h0, 8'h04, 4'h1, 32'h3);
        tick(2);
        check(d0_active, 1'b1);
        check(system_event, 1'b1);
        card = '0;
        wr(2'h0, 8'h88, 4'h1, 32'h7);
        tick(2);
        check(system_event, 1'b0);
        for (int k = 0; k < 2; k++) begin
            card = k ? 5'b00101 : 5'b00010;
            tick(2);
            rd(8'h88);
            check(rdata & 32'h7, k ? 32'h2 : 32'h4);
            card = '0;
            wr(2'h0, 8'h88, 4'h1, 32'h7);
        end
        tick(2);
        check(ring_pme_pin_n, 1'b1);
        wr(2'h0, 8'h80, 4'h1, 32'h1);
        wr(2'h0, 8'h8c, 4'h1, 32'h1);
        wr(2'h0, 8'ha4, 4'h1, 32'h2);
        tick(2);
        check(ring_pme_pin_n, 1'b0);
        check(power_state_field, 2'h2);
        sleep_hold = 1'b1;
        card = 5'b11000;
        tick(2);
        check(host_bus_float, 1'b1);
        check(bus_clock_gated, 1'b1);
        check({multifunction_pin_two_n, multifunction_pin_four_n}, 2'b01);
        cfg_req.rd = 1'b1;
        tick(1);
        cfg_req.rd = 1'b0;
        check(cfg_ack, 1'b0);
        // with grant the transfer still completes under sleep-hold
        rd(8'h14);
        check(rdata, 32'h0000_00a0);
        global_reset_in = 1'b1;
        host_bus_reset_in = 1'b1;
        tick(3);
        global_reset_in = 1'b0;
        host_bus_reset_in = 1'b0;
        tick(1);
        sleep_hold = 1'b0;
        card = '0;
        check(power_state_field, 2'h2);
        rd(8'h88);
        check(rdata & 32'h0700, 32'h0700);
        check(host_bus_float, 1'b0);
        wr(2'h0, 8'ha4, 4'h1, 32'h3);
        host_bus_reset_in = 1'b1;
        tick(2);
        check(power_state_field, 2'h3);
        host_bus_reset_in = 1'b0;
        tick(2);
        check({power_state_field, d0_active}, 3'h0);
        rd(8'ha4);
        check(rdata & 32'h8100, 32'h8100);
        wr(2'h0, 8'ha4, 4'h2, 32'h0);
        host_bus_reset_in = 1'b1;
        tick(2);
        host_bus_reset_in = 1'b0;
        rd(8'ha4);
        check(rdata & 32'h8100, 32'h0);
        global_reset_in = 1'b1;
        tick(2);
        global_reset_in = 1'b0;
        rd(8'h88);
        check(rdata & 32'h0700, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
